// ---- bench/ee2w_master_model.sv ----
// Behavioural two-wire bus master that drives the clock line and pulls data low.
// Assumes a pull-up on the data line; the bench resolves the wired-AND level.
`timescale 1ns/1ps
module ee2w_master_model (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	// Quarter of the 80 ns bus clock period.
	localparam int Q = 20;

	// Bus clock stands high and data is released outside frames.
	initial
	begin
		scl_o    = 1'b1;
		sda_oe_o = 1'b0;
	end

	// Release data, raise clock, then pull data low; also serves as repeated start.
	task automatic start_cond();
		#3;
		sda_oe_o = 1'b0;
		#(3 * Q);
		scl_o = 1'b1;
		#(2 * Q);
		sda_oe_o = 1'b1;
		#(2 * Q);
		scl_o = 1'b0;
	endtask : start_cond

	// Data rises while the clock is high to close the frame.
	task automatic stop_cond();
		#Q;
		sda_oe_o = 1'b1;
		#Q;
		scl_o = 1'b1;
		#(2 * Q);
		sda_oe_o = 1'b0;
		#(2 * Q);
	endtask : stop_cond

	// One clock: data changes only mid-low, the line is sampled late in the high phase.
	task automatic bit_xfer(input logic b, output logic r);
		#Q;
		sda_oe_o = ~b;
		#Q;
		scl_o = 1'b1;
		#(2 * Q - 4);
		r = sda_i;
		#4;
		scl_o = 1'b0;
	endtask : bit_xfer

	// Eight bits MSB first, then release for the slave's acknowledge.
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], r);
		bit_xfer(1'b1, r);
		ack = ~r;
	endtask : send_byte

	// Eight released bits in, then acknowledge or leave the line high to end a read.
	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(1'b1, d[i]);
		bit_xfer(~ack, r);
	endtask : recv_byte

endmodule : ee2w_master_model

// ---- bench/ee2w_slave_test.sv ----
// Self-checking bench for the two-wire EEPROM slave with a bus master model.
// Assumes a shortened programming time; write lock and clock enable are driven.
`timescale 1ns/1ps
module ee2w_slave_test;
	import ee2w_pkg::*;

	localparam int PROG_N = 300;

	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       ce = 1'b1;
	logic       wp = 1'b0;
	logic       scl;
	logic       m_oe;
	logic       sda;
	logic       sda_o;
	logic       sda_oe;
	logic       standby;
	logic       busy;
	logic [7:0] dat [8];
	int         busy_cycles = 0;
	int         n_mismatch = 0;
	int         checked = 0;

	// System clock, 100 MHz.
	always #5 clk = ~clk;

	// Wired-AND of both parties and the pull-up.
	assign sda = (m_oe ? 1'b0 : 1'b1) & (sda_oe ? sda_o : 1'b1);

	ee2w_slave #(.ADDR_W(8), .PROG_CYC(PROG_N)) uut (
		.CLOCK_I  (clk),
		.SYS_RST_I(rst),
		.CE_I     (ce),
		.SCL_I    (scl),
		.SDA_I    (sda),
		.SDA_O    (sda_o),
		.SDA_OE_O (sda_oe),
		.WP_I     (wp),
		.STANDBY_O(standby),
		.BUSY_O   (busy)
	);

	ee2w_master_model mst (
		.sda_i   (sda),
		.scl_o   (scl),
		.sda_oe_o(m_oe)
	);

	// Counts the enabled cycles for which each programming cycle keeps the busy flag up.
	always @(posedge clk)
		if (busy === 1'b1 && ce === 1'b1)
			busy_cycles <= busy_cycles + 1;

	// Whenever the device takes the line it must pull low.
	always @(posedge sda_oe)
		check({15'h0, sda_o}, 16'h0);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("Counts: %0d mismatches, %0d comparisons", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	// Write frame: command, address, n data bytes from dat, then STOP.
	task automatic page_write(input logic [7:0] cmd, input logic [7:0] addr, input int n);
		logic ack;
		busy_cycles = 0;
		mst.start_cond();
		mst.send_byte(cmd, ack);
		check({15'h0, ack}, 16'h1);
		mst.send_byte(addr, ack);
		check({15'h0, ack}, 16'h1);
		for (int i = 0; i < n; i++)
		begin
			mst.send_byte(dat[i], ack);
			check({15'h0, ack}, 16'h1);
		end
		mst.stop_cond();
	endtask : page_write

	// Waits out a programming cycle, bounded, and checks its length and the return to standby.
	task automatic wait_prog(input logic launched);
		int cnt;
		cnt = 0;
		repeat (5) @(posedge clk);
		check({15'h0, busy}, {15'h0, launched});
		while (busy === 1'b1 && cnt < PROG_N + 10)
		begin
			@(posedge clk);
			cnt++;
		end
		@(posedge clk);
		check(busy_cycles[15:0], launched ? PROG_N[15:0] : 16'h0);
		check({15'h0, standby}, 16'h1);
	endtask : wait_prog

	// Random read of n bytes from addr, compared against dat.
	task automatic rd_at(input logic [7:0] addr, input int n);
		logic       ack;
		logic [7:0] d;
		mst.start_cond();
		mst.send_byte(8'ha0, ack);
		mst.send_byte(addr, ack);
		mst.start_cond();
		mst.send_byte(8'ha1, ack);
		check({15'h0, ack}, 16'h1);
		for (int i = 0; i < n; i++)
		begin
			mst.recv_byte(i < n - 1, d);
			check({8'h0, d}, {8'h0, dat[i]});
		end
		mst.stop_cond();
		repeat (5) @(posedge clk);
		check({15'h0, busy}, 16'h0);
	endtask : rd_at

	// Byte write with don't-care command bits, polling during and after the cycle.
	task automatic t_byte_write();
		logic       ack;
		logic [7:0] d;
		dat[0] = 8'h5a;
		page_write(8'hae, 8'h12, 1);
		repeat (5) @(posedge clk);
		check({15'h0, standby}, 16'h0);
		mst.start_cond();
		mst.send_byte(8'ha0, ack);
		check({15'h0, ack}, 16'h0);
		mst.stop_cond();
		wait_prog(1'b1);
		mst.start_cond();
		mst.send_byte(8'ha1, ack);
		check({15'h0, ack}, 16'h1);
		mst.recv_byte(1'b0, d);
		check({8'h0, d}, 16'h005a);
		mst.stop_cond();
		dat[1] = 8'hff;
		rd_at(8'h12, 2);
	endtask : t_byte_write

	// Page writes: wrap inside the page, untouched neighbours, and a full eight bytes.
	task automatic t_page();
		dat[0] = 8'h11;
		dat[1] = 8'h22;
		dat[2] = 8'h33;
		page_write(8'ha0, 8'h3e, 3);
		wait_prog(1'b1);
		dat[2] = 8'hff;
		rd_at(8'h3e, 3);
		dat[0] = 8'h33;
		dat[1] = 8'hff;
		rd_at(8'h38, 2);
		for (int i = 0; i < 8; i++)
			dat[i] = 8'h80 + 8'(i);
		page_write(8'ha0, 8'h50, 8);
		wait_prog(1'b1);
		rd_at(8'h50, 8);
	endtask : t_page

	// Write lock blocks programming; a foreign command tag gets no acknowledge.
	task automatic t_refusals();
		logic ack;
		wp <= 1'b1;
		repeat (5) @(posedge clk);
		dat[0] = 8'h00;
		page_write(8'ha0, 8'h12, 1);
		wait_prog(1'b0);
		wp <= 1'b0;
		repeat (5) @(posedge clk);
		dat[0] = 8'h5a;
		rd_at(8'h12, 1);
		mst.start_cond();
		mst.send_byte(8'hb0, ack);
		check({15'h0, ack}, 16'h0);
		mst.send_byte(8'h12, ack);
		check({15'h0, ack}, 16'h0);
		mst.stop_cond();
		repeat (5) @(posedge clk);
		check({15'h0, standby}, 16'h1);
	endtask : t_refusals

	// Clock enable low freezes a running cycle; acknowledge polling then waits it out.
	task automatic t_freeze();
		logic       ack;
		logic [7:0] d;
		int         n;
		dat[0] = 8'hc3;
		page_write(8'ha0, 8'h24, 1);
		repeat (5) @(posedge clk);
		ce <= 1'b0;
		repeat (PROG_N + 20) @(posedge clk);
		check({15'h0, busy}, 16'h1);
		ce <= 1'b1;
		ack = 1'b0;
		n = 0;
		while (!ack && n < 20)
		begin
			mst.start_cond();
			mst.send_byte(8'ha1, ack);
			if (ack)
			begin
				check({15'h0, busy}, 16'h0);
				mst.recv_byte(1'b0, d);
				check({8'h0, d}, 16'h00c3);
			end
			mst.stop_cond();
			n++;
		end
		check({15'h0, ack}, 16'h1);
		check(busy_cycles[15:0], PROG_N[15:0]);
	endtask : t_freeze

	// Reset, then the scenarios in turn.
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		check({13'h0, standby, busy, sda_oe}, 16'h4);
		dat[0] = 8'hff;
		rd_at(8'h12, 1);
		t_byte_write();
		t_page();
		t_refusals();
		t_freeze();
		conclude();
	end

	// Cuts a hang short.
	initial
	begin
		#400000;
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end

endmodule : ee2w_slave_test

// ---- rtl/ee2w_pkg.sv ----
// Shared constants and types for the two-wire EEPROM slave front end.
// Assumes a 100 MHz system clock; the bus clock arrives from the master.
package ee2w_pkg;

	// System clock period and the longest allowed programming time.
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          PROG_TIME_NS  = 8000000;
	localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS; // Longest time, rounded down.

	// Command byte layout: device tag in the top nibble, direction in bit 0.
	localparam logic [3:0]  CMD_TAG       = 4'ha;
	localparam int          CMD_TAG_POS   = 4;
	localparam int          CMD_RW_POS    = 0;

	// Array and page geometry.
	localparam int          ADDR_W_DEF    = 8;
	localparam int          PAGE_BYTES    = 8;
	localparam int          PAGE_IDX_W    = 3;

	// Bit counter codes: waiting for the first low clock, the eighth bit, and the ninth clock.
	localparam logic [3:0]  BIT_PRE       = 4'hf;
	localparam logic [3:0]  BIT_LAST      = 4'h7;
	localparam logic [3:0]  BIT_ACK       = 4'h8;

	// Reset values.
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam logic        PROT_ERASED   = 1'b1;
	localparam logic [3:0]  PINS_IDLE     = 4'hf;

	// Bus transfer phases.
	typedef enum {S_IDLE, S_CMD, S_ADDR, S_WDATA, S_READ, S_IGNORE} ee2w_state_type;

	// Programming cycle phases.
	typedef enum {PG_IDLE, PG_ERASE, PG_WAIT, PG_WRITE} ee2w_prog_type;

	// Synchronised pin levels.
	typedef struct packed {
		logic scl;
		logic sda;
		logic bit_in;
		logic wp;
	} ee2w_pins_type;

	// Bus conditions seen on the synchronised lines, one cycle each.
	typedef struct packed {
		logic start;
		logic stop;
		logic fall;
	} ee2w_evt_type;

endpackage : ee2w_pkg

// ---- rtl/ee2w_slave.sv ----
// Two-wire serial EEPROM slave: bus conditions, command decode, acknowledge,
// address counter, page buffer and the self-timed erase/write cycle.
// Assumes a bus master drives the clock line; data sits in flip-flops.
//
// Function
// - Sample on clock rise, drive on fall.
// - Data line open drain, never driven high.
// - Write-lock input high blocks all programming.
// - START and STOP framed while clock high.
// - STOP launches programming or ends read.
// - Standby after STOP or finished programming.
// - Receiver pulls data low on ninth clock.
// - Nine clocks per byte, MSB first.
// - Command tag 1010, bit zero selects direction.
// - Byte after write command loads address.
// - Address advances per written or read byte.
// - Reads continue while master acknowledges.
// - Byte write: command, address, data, STOP.
// - Programming erases to ones, then writes.
// - Programming finishes within eight milliseconds.
// - Up to eight bytes held until STOP.
// - Writes increment only low three address bits.
// - Unaddressed page bytes left untouched.
// - No command acknowledge while programming runs.
// - Address holds last entered byte afterwards.
// - Repeated START aborts write, no programming.
// - Array of pages with one flag each.
// - Protected page suppresses programming requests.
`timescale 1ns/1ps
module ee2w_slave
	import ee2w_pkg::*;
#(
	parameter int ADDR_W   = ADDR_W_DEF,
	parameter int PROG_CYC = PROG_CYCLES
) (
	input  wire logic CLOCK_I,
	input  wire logic SYS_RST_I,
	input  wire logic CE_I,
	input  wire logic SCL_I,
	input  wire logic SDA_I,
	output logic      SDA_O,
	output logic      SDA_OE_O,
	input  wire logic WP_I,
	output logic      STANDBY_O,
	output logic      BUSY_O
);

	localparam int MEM_BYTES = 2 ** ADDR_W;
	localparam int PAGES     = MEM_BYTES / PAGE_BYTES;
	localparam int PAGE_W    = ADDR_W - PAGE_IDX_W;

	logic                  bit_cap_reg;
	ee2w_pins_type         pins_s;
	logic                  scl_q_reg;
	logic                  sda_q_reg;
	ee2w_evt_type          evt;
	ee2w_state_type        state_reg;
	ee2w_prog_type         pg_reg;
	logic [3:0]            cnt_reg;
	logic [7:0]            shreg_reg;
	logic [7:0]            tx_reg;
	logic [7:0]            byte_in;
	logic                  ack_now;
	logic [ADDR_W-1:0]     addr_reg;
	logic [ADDR_W-1:0]     last_reg;
	logic                  sda_oe_reg;
	logic [PAGE_BYTES-1:0] sel_reg;
	logic [7:0]            buf_reg [PAGE_BYTES];
	logic [7:0]            mem_reg [MEM_BYTES];
	logic [PAGES-1:0]      prot_reg;
	logic [PAGE_W-1:0]     page_reg;
	logic [31:0]           prog_cnt_reg;
	logic                  busy;
	logic                  launch;
	logic                  act;
	logic [31:0]           prog_len_reg;

	// Bus clock domain: the data bit is captured on each rising clock edge.
	always_ff @(posedge SCL_I)
	begin
		bit_cap_reg <= SDA_I;
	end

	// Pins and the captured bit cross into the system clock domain as levels.
	ee2w_sync #(
		.W       (4),
		.RST_VAL (PINS_IDLE)
	) u_sync (
		.clk_i (CLOCK_I),
		.rst_i (SYS_RST_I),
		.ce_i  (CE_I),
		.d_i   ({SCL_I, SDA_I, bit_cap_reg, WP_I}),
		.q_o   (pins_s)
	);

	// Previous synchronised levels for edge detection.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end
		else if (CE_I)
		begin
			scl_q_reg <= pins_s.scl;
			sda_q_reg <= pins_s.sda;
		end
	end

	// Bus conditions: data edges while the clock stays high frame a transfer.
	always_comb
	begin
		evt.start = CE_I & scl_q_reg & pins_s.scl & sda_q_reg & ~pins_s.sda;
		evt.stop  = CE_I & scl_q_reg & pins_s.scl & ~sda_q_reg & pins_s.sda;
		evt.fall  = CE_I & scl_q_reg & ~pins_s.scl;
	end

	// Byte decode and acknowledge decision at the end of the eighth bit.
	assign byte_in = {shreg_reg[6:0], pins_s.bit_in};
	assign busy    = (pg_reg != PG_IDLE);
	assign act     = evt.fall && (cnt_reg == BIT_ACK)
		&& (state_reg != S_IDLE) && (state_reg != S_IGNORE);
	always_comb
	begin
		case (state_reg)
			S_CMD:   ack_now = (byte_in[7:CMD_TAG_POS] == CMD_TAG) && !busy;
			S_ADDR:  ack_now = 1'b1;
			S_WDATA: ack_now = 1'b1;
			default: ack_now = 1'b0;
		endcase
	end

	// A STOP after entered data starts programming unless locked or protected.
	assign launch = evt.stop && (state_reg == S_WDATA) && (sel_reg != '0) && !busy
		&& !pins_s.wp
		&& prot_reg[addr_reg[ADDR_W-1:PAGE_IDX_W]];

	// Transfer sequencer: conditions first, then one step per falling clock.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			state_reg  <= S_IDLE;
			cnt_reg    <= BIT_PRE;
			shreg_reg  <= 8'h00;
			tx_reg     <= 8'h00;
			addr_reg   <= '0;
			last_reg   <= '0;
			sda_oe_reg <= 1'b0;
		end
		else if (CE_I)
		begin
			if (evt.start)
			begin
				state_reg  <= S_CMD;
				cnt_reg    <= BIT_PRE;
				sda_oe_reg <= 1'b0;
			end
			else if (evt.stop)
			begin
				state_reg  <= S_IDLE;
				sda_oe_reg <= 1'b0;
			end
			else if (evt.fall && (state_reg != S_IDLE) && (state_reg != S_IGNORE))
			begin
				if (cnt_reg == BIT_PRE)
				begin
					cnt_reg <= 4'h0;
				end
				else if (cnt_reg == BIT_ACK)
				begin
					// Ninth clock over: act on the byte and set up the next one.
					cnt_reg    <= 4'h0;
					sda_oe_reg <= 1'b0;
					case (state_reg)
						S_CMD:
						begin
							if (!sda_oe_reg)
							begin
								state_reg <= S_IGNORE;
							end
							else if (shreg_reg[CMD_RW_POS])
							begin
								state_reg  <= S_READ;
								tx_reg     <= mem_reg[addr_reg];
								sda_oe_reg <= ~mem_reg[addr_reg][7];
								addr_reg   <= addr_reg + 1'b1;
							end
							else
							begin
								state_reg <= S_ADDR;
							end
						end
						S_ADDR:
						begin
							addr_reg  <= shreg_reg[ADDR_W-1:0];
							state_reg <= S_WDATA;
						end
						S_WDATA:
						begin
							last_reg <= addr_reg;
							addr_reg <= {addr_reg[ADDR_W-1:PAGE_IDX_W],
								addr_reg[PAGE_IDX_W-1:0] + 3'h1};
						end
						S_READ:
						begin
							if (!pins_s.bit_in)
							begin
								tx_reg     <= mem_reg[addr_reg];
								sda_oe_reg <= ~mem_reg[addr_reg][7];
								addr_reg   <= addr_reg + 1'b1;
							end
							else
							begin
								state_reg <= S_IGNORE;
							end
						end
						default:
						begin
							state_reg <= S_IGNORE;
						end
					endcase
				end
				else
				begin
					// Data bits: shift in the captured bit, shift out the read byte.
					shreg_reg <= byte_in;
					cnt_reg   <= cnt_reg + 4'h1;
					if (state_reg == S_READ)
					begin
						sda_oe_reg <= (cnt_reg == BIT_LAST) ? 1'b0 : ~tx_reg[6];
						tx_reg     <= {tx_reg[6:0], 1'b0};
					end
					else if (cnt_reg == BIT_LAST)
					begin
						sda_oe_reg <= ack_now;
					end
				end
			end
			// Reload beside the bit logic, so a clock fall in this cycle is never lost.
			if (pg_reg == PG_WRITE)
			begin
				addr_reg <= last_reg;
			end
		end
	end

	// Page buffer and its byte-select mask; a new command clears the mask unless programming runs.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			sel_reg <= '0;
			for (int i = 0; i < PAGE_BYTES; i++)
			begin
				buf_reg[i] <= 8'h00;
			end
		end
		else if (CE_I)
		begin
			if (evt.start && !busy)
			begin
				sel_reg <= '0;
			end
			else if (act && (state_reg == S_WDATA))
			begin
				buf_reg[addr_reg[PAGE_IDX_W-1:0]] <= shreg_reg;
				sel_reg[addr_reg[PAGE_IDX_W-1:0]] <= 1'b1;
			end
		end
	end

	// Per-page protection flags, all in the erased, writable state.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			prot_reg <= {PAGES{PROT_ERASED}};
		end
	end

	// Self-timed cycle: erase the selected bytes, wait, then write them.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			pg_reg       <= PG_IDLE;
			page_reg     <= '0;
			prog_cnt_reg <= 32'h0;
		end
		else if (CE_I)
		begin
			case (pg_reg)
				PG_IDLE:
				begin
					if (launch)
					begin
						pg_reg   <= PG_ERASE;
						page_reg <= addr_reg[ADDR_W-1:PAGE_IDX_W];
					end
				end
				PG_ERASE:
				begin
					pg_reg       <= PG_WAIT;
					prog_cnt_reg <= 32'h0;
				end
				PG_WAIT:
				begin
					prog_cnt_reg <= prog_cnt_reg + 32'h1;
					if (prog_cnt_reg >= 32'(PROG_CYC - 3))
					begin
						pg_reg <= PG_WRITE;
					end
				end
				PG_WRITE:
				begin
					pg_reg <= PG_IDLE;
				end
				default:
				begin
					pg_reg <= PG_IDLE;
				end
			endcase
		end
	end

	// Array storage: only bytes entered in the page buffer are touched.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			for (int i = 0; i < MEM_BYTES; i++)
			begin
				mem_reg[i] <= ERASED_BYTE;
			end
		end
		else if (CE_I)
		begin
			for (int i = 0; i < PAGE_BYTES; i++)
			begin
				if (sel_reg[i] && (pg_reg == PG_ERASE))
				begin
					mem_reg[{page_reg, PAGE_IDX_W'(i)}] <= ERASED_BYTE;
				end
				else if (sel_reg[i] && (pg_reg == PG_WRITE))
				begin
					mem_reg[{page_reg, PAGE_IDX_W'(i)}] <= buf_reg[i];
				end
			end
		end
	end

	// Outputs: the line is only ever pulled low, never driven high.
	assign SDA_O     = 1'b0;
	assign SDA_OE_O  = sda_oe_reg;
	assign BUSY_O    = busy;
	assign STANDBY_O = (state_reg == S_IDLE) && !busy;

	// Length of the current programming cycle, for checking only.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I || !busy)
		begin
			prog_len_reg <= 32'h0;
		end
		else if (CE_I)
		begin
			prog_len_reg <= prog_len_reg + 32'h1;
		end
	end

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (SYS_RST_I);

	// Eighth bit of a command byte completes on this falling clock.
	sequence cmd_done_s;
		evt.fall && (cnt_reg == BIT_LAST) && (state_reg == S_CMD);
	endsequence

	// Ninth clock of an entered data byte ends on this falling clock.
	sequence data_act_s;
		act && (state_reg == S_WDATA);
	endsequence

	odrain_drive_a: assert property (SDA_O == 1'b0)
		else $error("Data line driven high.");
	oe_on_fall_a: assert property (!$stable(sda_oe_reg) |-> $past(evt.fall || evt.start || evt.stop))
		else $error("Data output changed without a falling clock.");
	busy_nack_a: assert property (cmd_done_s ##0 busy |=> !sda_oe_reg)
		else $error("Command acknowledged during programming.");
	bad_tag_a: assert property (cmd_done_s ##0 (byte_in[7:CMD_TAG_POS] != CMD_TAG) |=> !sda_oe_reg)
		else $error("Foreign command byte acknowledged.");
	good_tag_a: assert property (cmd_done_s ##0 ((byte_in[7:CMD_TAG_POS] == CMD_TAG) && !busy) |=> sda_oe_reg)
		else $error("Idle device failed to acknowledge its command.");
	stop_launch_a: assert property (launch |=> (pg_reg == PG_ERASE) && (state_reg == S_IDLE))
		else $error("Programming not launched by STOP.");
	stop_idle_a: assert property (evt.stop |=> (state_reg == S_IDLE) && !sda_oe_reg)
		else $error("STOP did not return the bus side to standby.");
	lock_block_a: assert property (evt.stop && pins_s.wp && !busy |=> !busy)
		else $error("Programming started with the write lock set.");
	prog_len_a: assert property (prog_len_reg <= 32'(PROG_CYC))
		else $error("Programming cycle ran too long.");
	page_fixed_a: assert property (data_act_s |=> addr_reg[ADDR_W-1:PAGE_IDX_W]
		== $past(addr_reg[ADDR_W-1:PAGE_IDX_W]))
		else $error("Page bits moved during data entry.");
	addr_hold_a: assert property ((pg_reg == PG_WRITE) && CE_I |=> addr_reg == last_reg)
		else $error("Address counter lost the last entered byte.");
	rstart_abort_a: assert property (evt.start && (state_reg == S_WDATA) && !busy |=> !busy)
		else $error("Repeated START launched programming.");

endmodule : ee2w_slave

// ---- rtl/ee2w_sync.sv ----
// Two-stage level synchroniser for a group of asynchronous inputs.
// Assumes each input is a slow level; the first stage feeds only the second.
`timescale 1ns/1ps
module ee2w_sync #(
	parameter int         W       = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_reg;

	// Both stages load the reset value, then shift the input through.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= RST_VAL;
			q_o      <= RST_VAL;
		end
		else if (ce_i)
		begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end

endmodule : ee2w_sync
